//--- src/pga_pkg.sv
package pga_pkg;

	// ----------------------------------------------------------------
	// Sources and sizes
	// ----------------------------------------------------------------
	localparam int PGA_NSRC  = 7;
	localparam int PGA_NCONV = 3;
	localparam int PGA_NRAIL = 6;
	localparam int PGA_NFLAG = 13;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int PGA_CLK_HZ     = 40000000;
	localparam int PGA_CYC_PER_US = PGA_CLK_HZ / 1000000;
	localparam int PGA_GATE_US    = 800;
	localparam int PGA_GATE_CYC   = PGA_GATE_US * PGA_CYC_PER_US;
	localparam int PGA_RISE_MS    = 11;
	localparam int PGA_RISE_CYC   = PGA_RISE_MS * 1000 * PGA_CYC_PER_US;
	localparam int PGA_DEB_US     = 10;
	localparam int PGA_DEB_CYC    = PGA_DEB_US * PGA_CYC_PER_US;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PGA_OFF_MON   = 8'h00;
	localparam logic [7:0] PGA_OFF_MASK  = 8'h04;
	localparam logic [7:0] PGA_OFF_SRC_A = 8'h08;
	localparam logic [7:0] PGA_OFF_SRC_B = 8'h0C;
	localparam logic [7:0] PGA_OFF_CFG   = 8'h10;
	localparam logic [7:0] PGA_OFF_FLT_A = 8'h14;
	localparam logic [7:0] PGA_OFF_FLT_B = 8'h18;
	localparam logic [7:0] PGA_OFF_FLAGS = 8'h1C;
	localparam logic [7:0] PGA_OFF_STAT  = 8'h20;

	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	localparam int PGA_MON_WIN     = 6;
	localparam int PGA_CFG_POL     = 0;
	localparam int PGA_CFG_OD      = 1;
	localparam int PGA_CFG_DLY     = 2;
	localparam int PGA_CFG_MODE    = 3;
	localparam int PGA_CFG_HOLD    = 4;
	localparam int PGA_CFG_STRIDE  = 8;
	localparam int PGA_FLG_SD      = 7;
	localparam int PGA_FLG_OVP     = 8;
	localparam int PGA_FLG_RST     = 9;
	localparam int PGA_FLG_SC_LSB  = 10;
	localparam logic [12:0] PGA_MASKABLE = 13'h027F;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [6:0]  PGA_RST_MON  = 7'h00;
	localparam logic [12:0] PGA_RST_MASK = 13'h0000;
	localparam logic [6:0]  PGA_RST_SRC  = 7'h00;
	localparam logic [4:0]  PGA_RST_CFG  = 5'h01;

	typedef enum logic {PGA_ST_OFF, PGA_ST_RUN} pga_state_t;

endpackage

//--- src/pga_mon_if.sv
interface pga_mon_if;
	logic [pga_pkg::PGA_NSRC-1:0] in_win;
	logic [pga_pkg::PGA_NSRC-1:0] ok;
	modport core (output in_win, input ok);
	modport mon (input in_win, output ok);
endinterface

//--- src/pga_debounce.sv
module pga_debounce #(
	parameter int DEB_CYC = pga_pkg::PGA_DEB_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	pga_mon_if.mon   mon
);
	localparam int N  = pga_pkg::PGA_NSRC;
	localparam int DW = $clog2(DEB_CYC + 1);

	logic [N-1:0]  ok;
	logic [DW-1:0] cnt [N];

	// ----------------------------------------------------------------
	// Per-source filter
	// ----------------------------------------------------------------
	// A source flips only after differing for DEB_CYC cycles in a row
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < N; i++) begin
			if (sys_rst || mon.in_win[i] == ok[i]) begin
				cnt[i] <= '0;
			end else if (cnt[i] == DW'(DEB_CYC - 1)) begin
				cnt[i] <= '0;
				ok[i]  <= mon.in_win[i];
			end else begin
				cnt[i] <= cnt[i] + 1'b1;
			end
			if (sys_rst) begin
				ok[i] <= 1'b0;
			end
		end
	end

	assign mon.ok = ok;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking dcb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_deb_hold;
		(mon.in_win == ok) |=> $stable(ok);
	endproperty
	a_deb_hold: assert property (p_deb_hold) else $error("debounced result moved without excursion");

	property p_deb_flip;
		$changed(ok[0]) |-> $past(cnt[0]) == DW'(DEB_CYC - 1);
	endproperty
	a_deb_flip: assert property (p_deb_flip) else $error("debounced result flipped early");

endmodule

//--- src/pga_top.sv
// The implementer's own choices: the register offsets and the strobed register port.
module pga_top #(
	parameter int GATE_CYC = pga_pkg::PGA_GATE_CYC,
	parameter int RISE_CYC = pga_pkg::PGA_RISE_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [15:0] rdata,
	input  wire logic [5:0]  uv_raw,
	input  wire logic [5:0]  ov_raw,
	input  wire logic        thermal_warn_raw,
	input  wire logic        thermal_sd_raw,
	input  wire logic        supply_ovp_raw,
	input  wire logic        supply_uvlo_raw,
	input  wire logic [2:0]  step_down_enable,
	input  wire logic [2:0]  conv_ramping,
	input  wire logic [2:0]  short_event,
	input  wire logic        otp_load_done,
	input  wire logic        otp_mode_a,
	input  wire logic        otp_mode_b,
	input  wire logic        standby_reached,
	output logic             power_ok_out_a,
	output logic             power_ok_out_a_oe,
	output logic             power_ok_out_b,
	output logic             power_ok_out_b_oe,
	output logic             irq_out_low,
	output logic             irq_out_low_oe
);
	localparam int GW = $clog2(GATE_CYC + 1);
	localparam int RW = $clog2(RISE_CYC + 1);

	function automatic logic pga_hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
		return stb && (a == off);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [15:0] sync_a;
	logic [15:0] sync_b;
	wire  [15:0] raw_in = {supply_uvlo_raw, supply_ovp_raw, thermal_sd_raw, thermal_warn_raw, ov_raw, uv_raw};

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_a <= 16'h0000;
			sync_b <= 16'h0000;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	wire [5:0] uv_s   = sync_b[5:0];
	wire [5:0] ov_s   = sync_b[11:6];
	wire       twarn_s = sync_b[12];
	wire       tsd_s  = sync_b[13];
	wire       ovp_s  = sync_b[14];
	wire       uvlo_s = sync_b[15];

	// ----------------------------------------------------------------
	// Control registers and state
	// ----------------------------------------------------------------
	logic [6:0]  mon_en;
	logic [12:0] irq_mask;
	logic [12:0] flags;
	logic [6:0]  ok_q;
	logic        irq_oe_q;
	pga_pkg::pga_state_t st;

	wire run = (st == pga_pkg::PGA_ST_RUN);
	wire win_sel = mon_en[pga_pkg::PGA_MON_WIN];

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mon_en   <= pga_pkg::PGA_RST_MON;
			irq_mask <= pga_pkg::PGA_RST_MASK;
		end else begin
			if (pga_hit(wr_stb, addr, pga_pkg::PGA_OFF_MON)) begin
				mon_en <= wdata[6:0];
			end
			if (pga_hit(wr_stb, addr, pga_pkg::PGA_OFF_MASK)) begin
				irq_mask <= wdata[12:0];
			end
		end
	end

	// Lockout drops back to the off state at once; standby releases it
	always_ff @(posedge ref_clk) begin
		if (sys_rst || uvlo_s) begin
			st <= pga_pkg::PGA_ST_OFF;
		end else if (standby_reached) begin
			st <= pga_pkg::PGA_ST_RUN;
		end
	end

	// ----------------------------------------------------------------
	// Window check and debounce
	// ----------------------------------------------------------------
	pga_mon_if mon_bus ();

	wire [5:0] in_win_w = ~uv_s & ~({6{win_sel}} & ov_s);
	assign mon_bus.in_win = {~twarn_s, in_win_w};
	wire [6:0] ok = mon_bus.ok;

	pga_debounce u_deb (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.mon     (mon_bus.mon)
	);

	// ----------------------------------------------------------------
	// Gating timers
	// ----------------------------------------------------------------
	logic [2:0]    en_q;
	logic [2:0]    ramp_q;
	logic [GW-1:0] gate_cnt [3];
	logic [2:0]    gate_on;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			en_q   <= 3'h0;
			ramp_q <= 3'h0;
		end else begin
			en_q   <= step_down_enable;
			ramp_q <= conv_ramping;
		end
	end

	for (genvar i = 0; i < pga_pkg::PGA_NCONV; i++) begin : g_gate
		wire restart = (step_down_enable[i] & ~en_q[i]) | (conv_ramping[i] & ~ramp_q[i]);
		always_ff @(posedge ref_clk) begin
			if (sys_rst || !step_down_enable[i]) begin
				gate_cnt[i] <= '0;
			end else if (restart) begin
				gate_cnt[i] <= GW'(GATE_CYC - 1);
			end else if (gate_cnt[i] != '0) begin
				gate_cnt[i] <= gate_cnt[i] - 1'b1;
			end
		end
		// The enable cycle itself is gated too, else a rail still low at enable would fault at once
		assign gate_on[i] = restart | (gate_cnt[i] != '0);
	end

	// ----------------------------------------------------------------
	// Source evaluation
	// ----------------------------------------------------------------
	wire [2:0] mon_conv  = mon_en[2:0] & step_down_enable;
	wire [6:0] bad_now   = {~ok[6], mon_en[5:3] & ~ok[5:3], mon_conv & ~ok[2:0]};
	wire [6:0] bad_gated = bad_now & ~{4'h0, gate_on};
	wire [6:0] bad_cont  = bad_now | {4'h0, mon_conv & conv_ramping};

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	wire [6:0]  chg_en   = {1'b1, mon_en[5:3], mon_conv};
	wire [6:0]  pg_chg   = (ok ^ ok_q) & chg_en;
	wire [12:0] flag_set = {short_event, otp_load_done, ovp_s, tsd_s, pg_chg};
	wire [12:0] flag_clr = pga_hit(wr_stb, addr, pga_pkg::PGA_OFF_FLAGS) ? wdata[12:0] : 13'h0000;
	wire [12:0] eff_mask = irq_mask & pga_pkg::PGA_MASKABLE;
	wire        irq_pend = |(flags & ~eff_mask);
	wire        sd_pend  = flags[pga_pkg::PGA_FLG_SD] | flags[pga_pkg::PGA_FLG_OVP];

	// Level conditions re-set every cycle, so a write-one cannot clear them early
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flags    <= 13'h0000;
			ok_q     <= 7'h00;
			irq_oe_q <= 1'b0;
		end else begin
			flags    <= (flags & ~flag_clr) | flag_set;
			ok_q     <= ok;
			irq_oe_q <= irq_pend;
		end
	end

	assign irq_out_low    = 1'b0;
	assign irq_out_low_oe = irq_oe_q;

	// ----------------------------------------------------------------
	// Power-good pins
	// ----------------------------------------------------------------
	logic [6:0]    src      [2];
	logic [4:0]    cfg      [2];
	logic [6:0]    fault    [2];
	logic [RW-1:0] rise_cnt [2];
	logic [6:0]    det      [2];
	logic          good     [2];
	logic          act      [2];
	logic          pin_o    [2];
	logic          pin_oe   [2];
	wire  [1:0]    otp_mode = {otp_mode_b, otp_mode_a};

	for (genvar p = 0; p < 2; p++) begin : g_pin
		localparam logic [7:0] OFF_SRC = (p == 0) ? pga_pkg::PGA_OFF_SRC_A : pga_pkg::PGA_OFF_SRC_B;
		localparam logic [7:0] OFF_FLT = (p == 0) ? pga_pkg::PGA_OFF_FLT_A : pga_pkg::PGA_OFF_FLT_B;
		localparam int         CB      = p * pga_pkg::PGA_CFG_STRIDE;

		wire       mode_c = cfg[p][pga_pkg::PGA_CFG_MODE];
		wire [6:0] fclr   = pga_hit(wr_stb, addr, OFF_FLT) ? wdata[6:0] : flag_clr[6:0];
		wire       sc_hit = |(flags[pga_pkg::PGA_FLG_SC_LSB +: 3] & src[p][2:0]);
		wire       sys_pend = sd_pend | flags[pga_pkg::PGA_FLG_RST] | sc_hit;
		wire       hold_off = (~mode_c | cfg[p][pga_pkg::PGA_CFG_HOLD]) & (|fault[p]);
		wire       ready  = ~cfg[p][pga_pkg::PGA_CFG_DLY] | (rise_cnt[p] == RW'(RISE_CYC));
		wire       forced = ~run | uvlo_s | sd_pend;
		wire       lvl    = forced ? 1'b0 : (cfg[p][pga_pkg::PGA_CFG_POL] ? act[p] : ~act[p]);

		assign det[p]  = src[p] & (mode_c ? bad_cont : bad_gated);
		assign good[p] = run & ~sys_pend & ~(|det[p]) & ~hold_off;

		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				src[p]      <= pga_pkg::PGA_RST_SRC;
				cfg[p]      <= pga_pkg::PGA_RST_CFG;
				fault[p]    <= 7'h00;
				rise_cnt[p] <= '0;
				act[p]      <= 1'b0;
				pin_o[p]    <= 1'b0;
				pin_oe[p]   <= 1'b1;
			end else begin
				if (pga_hit(wr_stb, addr, OFF_SRC)) begin
					src[p] <= wdata[6:0];
				end
				if (otp_load_done) begin
					cfg[p][pga_pkg::PGA_CFG_MODE] <= otp_mode[p];
				end else if (pga_hit(wr_stb, addr, pga_pkg::PGA_OFF_CFG)) begin
					cfg[p] <= wdata[CB +: 5];
				end
				if (otp_load_done) begin
					fault[p] <= 7'h00;
				end else begin
					fault[p] <= (fault[p] & ~fclr) | det[p];
				end
				// Preloaded at configuration load, then cleared the next cycle because the reset flag set by the load holds good low
				if (otp_load_done) begin
					rise_cnt[p] <= RW'(RISE_CYC);
				end else if (!good[p]) begin
					rise_cnt[p] <= '0;
				end else if (rise_cnt[p] != RW'(RISE_CYC)) begin
					rise_cnt[p] <= rise_cnt[p] + 1'b1;
				end
				act[p] <= good[p] & ready;
				if (cfg[p][pga_pkg::PGA_CFG_OD]) begin
					pin_o[p]  <= 1'b0;
					pin_oe[p] <= ~lvl;
				end else begin
					pin_o[p]  <= lvl;
					pin_oe[p] <= 1'b1;
				end
			end
		end
	end

	assign power_ok_out_a    = pin_o[0];
	assign power_ok_out_a_oe = pin_oe[0];
	assign power_ok_out_b    = pin_o[1];
	assign power_ok_out_b_oe = pin_oe[1];

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	logic [15:0] rd_next;

	always_comb begin
		if (addr == pga_pkg::PGA_OFF_MON) begin
			rd_next = {9'h000, mon_en};
		end else if (addr == pga_pkg::PGA_OFF_MASK) begin
			rd_next = {3'h0, irq_mask};
		end else if (addr == pga_pkg::PGA_OFF_SRC_A) begin
			rd_next = {9'h000, src[0]};
		end else if (addr == pga_pkg::PGA_OFF_SRC_B) begin
			rd_next = {9'h000, src[1]};
		end else if (addr == pga_pkg::PGA_OFF_CFG) begin
			rd_next = {3'h0, cfg[1], 3'h0, cfg[0]};
		end else if (addr == pga_pkg::PGA_OFF_FLT_A) begin
			rd_next = {9'h000, fault[0]};
		end else if (addr == pga_pkg::PGA_OFF_FLT_B) begin
			rd_next = {9'h000, fault[1]};
		end else if (addr == pga_pkg::PGA_OFF_FLAGS) begin
			rd_next = {3'h0, flags};
		end else if (addr == pga_pkg::PGA_OFF_STAT) begin
			rd_next = {6'h00, run, act[1], act[0], ok};
		end else begin
			rd_next = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= rd_stb ? rd_next : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking dcb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_off_low;
		!run |=> (!pin_o[0] && pin_oe[0] && !pin_o[1] && pin_oe[1]);
	endproperty
	a_off_low: assert property (p_off_low) else $error("pin not driven low before standby");

	property p_sd_low;
		sd_pend |=> (!pin_o[0] && pin_oe[0] && !pin_o[1] && pin_oe[1]);
	endproperty
	a_sd_low: assert property (p_sd_low) else $error("pin not low under shutdown flag");

	property p_rst_pend;
		flags[pga_pkg::PGA_FLG_RST] |=> (!act[0] && !act[1]);
	endproperty
	a_rst_pend: assert property (p_rst_pend) else $error("pin active with reset flag pending");

	property p_gated_hold;
		(!cfg[0][pga_pkg::PGA_CFG_MODE] && (fault[0] != 7'h00)) |=> !act[0];
	endproperty
	a_gated_hold: assert property (p_gated_hold) else $error("gated pin active with fault pending");

	property p_cont_hold;
		(cfg[0][pga_pkg::PGA_CFG_MODE] && cfg[0][pga_pkg::PGA_CFG_HOLD] && (fault[0] != 7'h00)) |=> !act[0];
	endproperty
	a_cont_hold: assert property (p_cont_hold) else $error("fault hold did not keep pin inactive");

	property p_fault_set;
		det[0][0] |=> fault[0][0];
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault bit lost against clear");

	property p_cond_flag;
		tsd_s |=> flags[pga_pkg::PGA_FLG_SD];
	endproperty
	a_cond_flag: assert property (p_cond_flag) else $error("shutdown flag cleared while present");

	property p_irq_on;
		irq_pend |=> irq_out_low_oe;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt not driven for pending flag");

	property p_irq_rel;
		(flags == 13'h0000) |=> !irq_out_low_oe;
	endproperty
	a_irq_rel: assert property (p_irq_rel) else $error("interrupt held with no flag pending");

	property p_rise;
		(cfg[0][pga_pkg::PGA_CFG_DLY] && !good[0]) |=> !act[0] ##1 !act[0];
	endproperty
	a_rise: assert property (p_rise) else $error("pin asserted before rise delay");

	property p_gate;
		(gate_on[0] && !cfg[0][pga_pkg::PGA_CFG_MODE]) |-> !det[0][0];
	endproperty
	a_gate: assert property (p_gate) else $error("rail judged inside gating period");

	property p_dis_mask;
		!step_down_enable[0] |-> (!det[0][0] && !det[1][0] && !pg_chg[0]);
	endproperty
	a_dis_mask: assert property (p_dis_mask) else $error("disabled converter affected result");

	property p_ramp;
		(cfg[0][pga_pkg::PGA_CFG_MODE] && src[0][0] && mon_conv[0] && conv_ramping[0]) |=> !act[0];
	endproperty
	a_ramp: assert property (p_ramp) else $error("continuous pin active during ramp");

	property p_win;
		!win_sel |-> (in_win_w == ~uv_s);
	endproperty
	a_win: assert property (p_win) else $error("overvoltage checked with window bit clear");

endmodule

//--- sim/pga_sys_model.sv
module pga_sys_model (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic start,
	output logic      otp_load_done,
	output logic      standby_reached
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Start-up sequencer
	// ----------------------------------------------------------------
	logic [3:0] seq;

	// The load ends with a single pulse and standby follows a few cycles later, so the
	// window between the two shows whether the pins stay low until standby.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			seq <= 4'h0;
		end else if (start || seq != 4'h0) begin
			seq <= (seq == 4'hF) ? seq : seq + 4'h1;
		end
	end

	assign otp_load_done   = (seq == 4'h1);
	assign standby_reached = (seq >= 4'h4);
endmodule

//--- sim/power_good_aggregator_test.sv
module power_good_aggregator_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [15:0] rdata;
	logic [5:0]  uv_raw = 6'h00;
	logic [5:0]  ov_raw = 6'h00;
	logic        thermal_warn_raw = 1'b0;
	logic        thermal_sd_raw = 1'b0;
	logic        supply_ovp_raw = 1'b0;
	logic        supply_uvlo_raw = 1'b0;
	logic [2:0]  step_down_enable = 3'h0;
	logic [2:0]  conv_ramping = 3'h0;
	logic [2:0]  short_event = 3'h0;
	logic        otp_mode_a = 1'b0;
	logic        start = 1'b0;
	logic        otp_load_done;
	logic        standby_reached;
	logic        pa;
	logic        pa_oe;
	logic        pb;
	logic        pb_oe;
	logic        irq;
	logic        irq_oe;
	int          n_fail = 0;
	int          num_checks = 0;

	always #12.5 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	pga_sys_model pga_sys_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
		.otp_load_done(otp_load_done), .standby_reached(standby_reached));

	// Short gating and delay counts keep the run brief
	pga_top #(.GATE_CYC(20), .RISE_CYC(16)) pga_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.uv_raw(uv_raw), .ov_raw(ov_raw), .thermal_warn_raw(thermal_warn_raw),
		.thermal_sd_raw(thermal_sd_raw), .supply_ovp_raw(supply_ovp_raw),
		.supply_uvlo_raw(supply_uvlo_raw), .step_down_enable(step_down_enable),
		.conv_ramping(conv_ramping), .short_event(short_event), .otp_load_done(otp_load_done),
		.otp_mode_a(otp_mode_a), .otp_mode_b(1'b0), .standby_reached(standby_reached),
		.power_ok_out_a(pa), .power_ok_out_a_oe(pa_oe), .power_ok_out_b(pb),
		.power_ok_out_b_oe(pb_oe), .irq_out_low(irq), .irq_out_low_oe(irq_oe));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Pin view as {data, enable}: 0 pin a, 1 pin b, 2 interrupt
	function logic [1:0] cur(input int which);
		return (which == 0) ? {pa, pa_oe} : (which == 1) ? {pb, pb_oe} : {irq, irq_oe};
	endfunction

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		@(negedge ref_clk);
		chk(rdata, exp);
	endtask

	// Debounce plus synchroniser is about 402 cycles, so 1000 is a safe bound
	task wait_for(input int which, input logic [1:0] exp);
		int i;
		i = 0;
		@(negedge ref_clk);
		while (i < 1000 && cur(which) !== exp) begin
			@(negedge ref_clk);
			i++;
		end
		chk({14'h0, cur(which)}, {14'h0, exp});
		if (cur(which) !== exp) begin
			give_verdict();
		end
	endtask

	task stay(input int which, input logic [1:0] exp, input int n);
		logic [1:0] seen;
		seen = exp;
		repeat (n) begin
			@(negedge ref_clk);
			if (cur(which) !== exp) begin
				seen = cur(which);
			end
		end
		chk({14'h0, seen}, {14'h0, exp});
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(pga_pkg::PGA_OFF_MON, 16'h0000);
		rd(pga_pkg::PGA_OFF_MASK, 16'h0000);
		rd(pga_pkg::PGA_OFF_SRC_A, 16'h0000);
		rd(pga_pkg::PGA_OFF_CFG, 16'h0101);
		rd(8'h30, 16'h0000);
		stay(0, 2'b01, 20);
		stay(2, 2'b00, 1);
		@(posedge ref_clk);
		otp_mode_a <= 1'b1;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		wait_for(2, 2'b01);
		repeat (500) @(posedge ref_clk);
		stay(0, 2'b01, 5);
		rd(pga_pkg::PGA_OFF_CFG, 16'h0109);
		wr(pga_pkg::PGA_OFF_FLAGS, 16'h1FFF);
		wait_for(0, 2'b11);
		wait_for(2, 2'b00);
		// Continuous pin a on the supply input, fault hold on
		wr(pga_pkg::PGA_OFF_MON, 16'h0008);
		wr(pga_pkg::PGA_OFF_SRC_A, 16'h0008);
		wr(pga_pkg::PGA_OFF_CFG, 16'h0119);
		@(posedge ref_clk);
		uv_raw <= 6'h08;
		wait_for(0, 2'b01);
		rd(pga_pkg::PGA_OFF_FLT_A, 16'h0008);
		@(posedge ref_clk);
		uv_raw <= 6'h00;
		repeat (500) @(posedge ref_clk);
		stay(0, 2'b01, 5);
		rd(pga_pkg::PGA_OFF_FLT_A, 16'h0008);
		wr(pga_pkg::PGA_OFF_FLAGS, 16'h0008);
		rd(pga_pkg::PGA_OFF_FLT_A, 16'h0000);
		wait_for(0, 2'b11);
		// Overvoltage counts only with the window bit set
		wr(pga_pkg::PGA_OFF_CFG, 16'h0109);
		@(posedge ref_clk);
		ov_raw <= 6'h08;
		repeat (500) @(posedge ref_clk);
		stay(0, 2'b11, 5);
		wr(pga_pkg::PGA_OFF_MON, 16'h0048);
		wait_for(0, 2'b01);
		@(posedge ref_clk);
		ov_raw <= 6'h00;
		wait_for(0, 2'b11);
		wr(pga_pkg::PGA_OFF_FLT_A, 16'h0008);
		wr(pga_pkg::PGA_OFF_FLAGS, 16'h1FFF);
		// Pin b drive: open-drain active high releases, push-pull active low drives low
		wr(pga_pkg::PGA_OFF_CFG, 16'h0309);
		wait_for(1, 2'b00);
		wr(pga_pkg::PGA_OFF_CFG, 16'h0009);
		wait_for(1, 2'b01);
		wr(pga_pkg::PGA_OFF_CFG, 16'h0109);
		// Shutdown then supply overvoltage; clear refused while the condition stands
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk);
			{supply_ovp_raw, thermal_sd_raw} <= 2'b01 << k;
			wait_for(0, 2'b01);
			wait_for(1, 2'b01);
			wait_for(2, 2'b01);
			wr(pga_pkg::PGA_OFF_FLAGS, 16'h0080 << k);
			rd(pga_pkg::PGA_OFF_FLAGS, 16'h0080 << k);
			@(posedge ref_clk);
			{supply_ovp_raw, thermal_sd_raw} <= 2'b00;
			repeat (500) @(posedge ref_clk);
			stay(0, 2'b01, 3);
			wr(pga_pkg::PGA_OFF_FLAGS, 16'h0080 << k);
			wait_for(0, 2'b11);
			wait_for(2, 2'b00);
		end
		// Masked thermal warning sets its flag but leaves the interrupt quiet
		wr(pga_pkg::PGA_OFF_MASK, 16'h0040);
		@(posedge ref_clk);
		thermal_warn_raw <= 1'b1;
		repeat (500) @(posedge ref_clk);
		stay(2, 2'b00, 5);
		rd(pga_pkg::PGA_OFF_FLAGS, 16'h0040);
		wr(pga_pkg::PGA_OFF_MASK, 16'h0000);
		wait_for(2, 2'b01);
		@(posedge ref_clk);
		thermal_warn_raw <= 1'b0;
		repeat (500) @(posedge ref_clk);
		wr(pga_pkg::PGA_OFF_FLAGS, 16'h0040);
		wait_for(2, 2'b00);
		@(posedge ref_clk);
		short_event <= 3'h2;
		@(posedge ref_clk);
		short_event <= 3'h0;
		wait_for(2, 2'b01);
		wr(pga_pkg::PGA_OFF_FLAGS, 16'h0800);
		wait_for(2, 2'b00);
		@(posedge ref_clk);
		supply_uvlo_raw <= 1'b1;
		wait_for(0, 2'b01);
		@(posedge ref_clk);
		supply_uvlo_raw <= 1'b0;
		wait_for(0, 2'b11);
		// Gated pin b on converter 0 with its output already under
		wr(pga_pkg::PGA_OFF_MON, 16'h0001);
		wr(pga_pkg::PGA_OFF_SRC_B, 16'h0001);
		@(posedge ref_clk);
		uv_raw <= 6'h01;
		repeat (500) @(posedge ref_clk);
		stay(1, 2'b11, 5);
		@(posedge ref_clk);
		step_down_enable <= 3'h1;
		stay(1, 2'b11, 15);
		wait_for(1, 2'b01);
		rd(pga_pkg::PGA_OFF_FLT_B, 16'h0001);
		@(posedge ref_clk);
		step_down_enable <= 3'h0;
		uv_raw <= 6'h00;
		repeat (500) @(posedge ref_clk);
		wr(pga_pkg::PGA_OFF_FLT_B, 16'h0001);
		wr(pga_pkg::PGA_OFF_FLAGS, 16'h1FFF);
		wait_for(1, 2'b11);
		// Converter 0 ramping: continuous pin a drops, gated pin b stays good
		wr(pga_pkg::PGA_OFF_SRC_A, 16'h0001);
		@(posedge ref_clk);
		step_down_enable <= 3'h1;
		conv_ramping <= 3'h1;
		wait_for(0, 2'b01);
		stay(1, 2'b11, 5);
		@(posedge ref_clk);
		conv_ramping <= 3'h0;
		wait_for(0, 2'b11);
		rd(pga_pkg::PGA_OFF_FLT_A, 16'h0001);
		give_verdict();
	end
endmodule
